/* File: rtl/ext_exec.sv */
// execution unit for part of an 8-bit core's extended instruction group
// assumes one instruction issued per start pulse, operand byte valid with it,
// and program memory answering in the same cycle as its address
`timescale 1ns/1ps
`include "ext_exec_defines.svh"

// How it works
// - swap operand nibbles into accumulator, no flags
// - skip next when whole operand byte zero
// - taken skip lasts three cycles total
// - copy operand to accumulator, skip if zero
// - skip next when selected operand bit zero
// - paged table read: word at high:low pointer
// - last-page read uses only low pointer
// - paged read after incrementing low pointer
// - last-page read after incrementing low pointer
// - accumulator gets xor, zero flag only
// - memory gets xor, zero flag only
module ext_exec
    import ext_exec_pkg::*;
#(
    parameter int DATA_W = `DATA_W,
    parameter int PROG_W = `PROG_W,
    parameter int PROG_AW = `PROG_AW
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // instruction issue
    input wire logic start,
    input wire op_e op,
    input wire logic [DATA_W-1:0] operand,
    input wire logic [2:0] bit_sel,
    // table pointer load from the core
    input wire logic ptr_load,
    input wire logic [DATA_W-1:0] ptr_low_in,
    input wire logic [DATA_W-1:0] ptr_high_in,
    // program memory
    output logic [PROG_AW-1:0] prog_addr,
    output logic prog_rd,
    input wire logic [PROG_W-1:0] prog_data,
    // results
    output logic [DATA_W-1:0] accumulator,
    output logic zero_flag,
    output logic mem_we,
    output logic [DATA_W-1:0] mem_wdata,
    output logic [DATA_W-1:0] table_pointer_low,
    output logic [DATA_W-1:0] table_pointer_high,
    output logic [PROG_W-DATA_W-1:0] table_high_latch,
    output logic skip_next,
    output logic busy,
    output logic done
);

    typedef struct packed {
        state_e state;
        logic [DATA_W-1:0] accumulator;
        logic zero_flag;
        logic mem_we;
        logic [DATA_W-1:0] mem_wdata;
        logic [DATA_W-1:0] table_pointer_low;
        logic [DATA_W-1:0] table_pointer_high;
        logic [PROG_W-DATA_W-1:0] table_high_latch;
        logic [PROG_AW-1:0] prog_addr;
        logic prog_rd;
        logic skip_next;
        logic [1:0] skip_cnt;
        logic busy;
        logic done;
    } state_s;

    state_s r;
    state_s next_r;

    // last page is the top 256 words of program memory
    function automatic logic [PROG_AW-1:0] table_addr(input logic last,
            input logic [DATA_W-1:0] hi, input logic [DATA_W-1:0] lo);
        logic [PROG_W+DATA_W-1:0] full;
        full = '0;
        if (last) begin
            full[PROG_AW-1:0] = {{(PROG_AW-DATA_W){1'b1}}, lo};
        end else begin
            full[2*DATA_W-1:0] = {hi, lo};
        end
        return full[PROG_AW-1:0];
    endfunction

    always_comb begin
        logic [DATA_W-1:0] lo;
        logic [DATA_W-1:0] x;
        lo = r.table_pointer_low;
        x = r.accumulator ^ operand;
        next_r = r;
        next_r.mem_we = 1'b0;
        next_r.done = 1'b0;
        next_r.prog_rd = 1'b0;
        // loads only when idle, so a running table read keeps its pointer
        if (ptr_load && r.state == st_idle) begin
            next_r.table_pointer_low = ptr_low_in;
            next_r.table_pointer_high = ptr_high_in;
        end
        case (r.state)
            st_idle: begin
                next_r.skip_next = 1'b0;
                if (start) begin
                    // one-cycle ops finish at once; longer ones override below
                    next_r.done = 1'b1;
                    next_r.busy = 1'b0;
                    case (op)
                        op_swap_nibbles_to_acc: begin
                            next_r.accumulator = {operand[3:0], operand[7:4]};
                        end
                        op_skip_on_zero: begin
                            // counter spans the dummy cycles, not the issue or done edges
                            if (operand == '0) begin
                                next_r.state = st_skip;
                                next_r.skip_cnt = 2'(`SKIP_CYCLES - 2);
                                next_r.busy = 1'b1;
                                next_r.done = 1'b0;
                            end
                        end
                        op_copy_and_skip_on_zero: begin
                            next_r.accumulator = operand;
                            if (operand == '0) begin
                                next_r.state = st_skip;
                                next_r.skip_cnt = 2'(`SKIP_CYCLES - 2);
                                next_r.busy = 1'b1;
                                next_r.done = 1'b0;
                            end
                        end
                        op_skip_on_bit_zero: begin
                            if (!operand[bit_sel]) begin
                                next_r.state = st_skip;
                                next_r.skip_cnt = 2'(`SKIP_CYCLES - 2);
                                next_r.busy = 1'b1;
                                next_r.done = 1'b0;
                            end
                        end
                        op_table_read_paged, op_table_read_last_page,
                        op_inc_table_read_paged, op_inc_table_read_last_page: begin
                            if (op == op_inc_table_read_paged ||
                                    op == op_inc_table_read_last_page) begin
                                lo = r.table_pointer_low + 8'h01;
                                next_r.table_pointer_low = lo;
                            end
                            next_r.prog_addr = table_addr(op == op_table_read_last_page ||
                                op == op_inc_table_read_last_page,
                                r.table_pointer_high, lo);
                            next_r.prog_rd = 1'b1;
                            next_r.state = st_fetch;
                            next_r.busy = 1'b1;
                            next_r.done = 1'b0;
                        end
                        op_xor_into_acc: begin
                            next_r.accumulator = x;
                            next_r.zero_flag = (x == '0);
                        end
                        op_xor_into_memory: begin
                            next_r.mem_wdata = x;
                            next_r.mem_we = 1'b1;
                            next_r.zero_flag = (x == '0);
                        end
                        default: begin
                            next_r.done = 1'b1;
                        end
                    endcase
                end
            end
            st_fetch: begin
                // the word stands in the prog_rd cycle and is taken at its end
                next_r.mem_wdata = prog_data[DATA_W-1:0];
                next_r.table_high_latch = prog_data[PROG_W-1:DATA_W];
                next_r.mem_we = 1'b1;
                next_r.state = st_idle;
                next_r.busy = 1'b0;
                next_r.done = 1'b1;
            end
            st_skip: begin
                // dummy cycle stands in for the suppressed instruction
                next_r.skip_next = 1'b1;
                if (r.skip_cnt == 2'h0) begin
                    next_r.state = st_idle;
                    next_r.busy = 1'b0;
                    next_r.done = 1'b1;
                end else begin
                    next_r.skip_cnt = r.skip_cnt - 2'h1;
                end
            end
            default: begin
                next_r.state = st_idle;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
            r.state <= st_idle;
            r.accumulator <= `ACC_RST;
            r.table_pointer_low <= `TABLE_POINTER_LOW_RST;
            r.table_pointer_high <= `TABLE_POINTER_HIGH_RST;
            r.table_high_latch <= `TABLE_HIGH_LATCH_RST;
        end else begin
            r <= next_r;
        end
    end

    assign prog_addr = r.prog_addr;
    assign prog_rd = r.prog_rd;
    assign accumulator = r.accumulator;
    assign zero_flag = r.zero_flag;
    assign mem_we = r.mem_we;
    assign mem_wdata = r.mem_wdata;
    assign table_pointer_low = r.table_pointer_low;
    assign table_pointer_high = r.table_pointer_high;
    assign table_high_latch = r.table_high_latch;
    assign skip_next = r.skip_next;
    assign busy = r.busy;
    assign done = r.done;

    sequence skip_start_s;
        start && r.state == st_idle && op == op_skip_on_zero && operand == '0;
    endsequence

    sequence copy_zero_start_s;
        start && r.state == st_idle && op == op_copy_and_skip_on_zero && operand == '0;
    endsequence

    sequence bit_zero_start_s;
        start && r.state == st_idle && op == op_skip_on_bit_zero && !operand[bit_sel];
    endsequence

    // busy twice, skip_next shown, then done with busy low
    sequence dummy_cycles_s;
        busy && !done ##1 busy && skip_next ##1 done && skip_next && !busy;
    endsequence

    sequence table_walk_s;
        prog_rd && busy && !done ##1 mem_we && done && !busy;
    endsequence

    skip_three_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        skip_start_s |=> busy [*2] ##1 done)
        else $error("taken skip did not last three cycles");
    skip_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        skip_start_s |-> ##2 skip_next)
        else $error("zero operand did not skip");
    bit_skip_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (start && !busy && op == op_skip_on_bit_zero && operand[bit_sel]) |=> done && !busy)
        else $error("set bit caused a skip");
    swap_acc_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (start && !busy && op == op_swap_nibbles_to_acc)
        |=> accumulator == {$past(operand[3:0]), $past(operand[7:4])} && $stable(zero_flag))
        else $error("nibble swap wrong");
    copy_acc_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (start && !busy && op == op_copy_and_skip_on_zero) |=> accumulator == $past(operand))
        else $error("copy to accumulator wrong");
    xor_acc_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (start && !busy && op == op_xor_into_acc)
        |=> accumulator == ($past(accumulator) ^ $past(operand))
            && zero_flag == (accumulator == 8'h00))
        else $error("xor to accumulator wrong");
    xor_mem_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (start && !busy && op == op_xor_into_memory)
        |=> mem_we && mem_wdata == ($past(accumulator) ^ $past(operand)) && $stable(accumulator))
        else $error("xor to memory wrong");
    inc_ptr_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (start && !busy && op == op_inc_table_read_paged)
        |=> table_pointer_low == $past(table_pointer_low) + 8'h01 && prog_rd
            ##1 mem_we && done)
        else $error("incrementing table read wrong");
    last_page_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (start && !busy && op == op_table_read_last_page)
        |=> prog_addr[DATA_W-1:0] == table_pointer_low && &prog_addr[PROG_AW-1:DATA_W])
        else $error("last page address wrong");
    table_data_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (r.state == st_fetch) |=> mem_wdata == $past(prog_data[7:0])
            && table_high_latch == $past(prog_data[PROG_W-1:DATA_W]))
        else $error("table data split wrong");
    copy_skip_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        copy_zero_start_s |=> dummy_cycles_s)
        else $error("zero copy did not skip");
    bit_zero_skip_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        bit_zero_start_s |=> dummy_cycles_s)
        else $error("clear bit did not skip");
    skip_flags_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (start && !busy && (op == op_skip_on_zero || op == op_copy_and_skip_on_zero
            || op == op_skip_on_bit_zero)) |=> $stable(zero_flag))
        else $error("skip changed the zero flag");
    paged_addr_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (start && !busy && !ptr_load && op == op_table_read_paged)
        |=> prog_rd && prog_addr == PROG_AW'({table_pointer_high, table_pointer_low}))
        else $error("paged table address wrong");
    inc_last_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (start && !busy && op == op_inc_table_read_last_page)
        |=> table_pointer_low == $past(table_pointer_low) + 8'h01
            && prog_addr[DATA_W-1:0] == table_pointer_low && &prog_addr[PROG_AW-1:DATA_W])
        else $error("incrementing last page read wrong");
    table_steps_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (start && !busy && (op == op_table_read_paged || op == op_table_read_last_page
            || op == op_inc_table_read_paged || op == op_inc_table_read_last_page))
        |=> table_walk_s)
        else $error("table read steps wrong");
    table_acc_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (r.state == st_fetch) |=> $stable(accumulator) && $stable(zero_flag))
        else $error("table read touched accumulator or flag");

endmodule // ext_exec

/* File: rtl/ext_exec_defines.svh */
// constants for the extended-group execution unit
// assumes inclusion by the package and the execution module
`ifndef EXT_EXEC_DEFINES_SVH
`define EXT_EXEC_DEFINES_SVH
`define DATA_W 8
`define PROG_W 16
`define PROG_AW 11
`define SKIP_CYCLES 3
`define TABLE_POINTER_LOW_RST 8'h00
`define TABLE_POINTER_HIGH_RST 8'h00
`define TABLE_HIGH_LATCH_RST 8'h00
`define ACC_RST 8'h00
`endif

/* File: rtl/ext_exec_pkg.sv */
// types for the extended-group execution unit
// assumes the defines header sits beside it
`include "ext_exec_defines.svh"
package ext_exec_pkg;
    typedef enum logic [3:0] {
        op_none = 4'h0,
        op_swap_nibbles_to_acc = 4'h1,
        op_skip_on_zero = 4'h2,
        op_copy_and_skip_on_zero = 4'h3,
        op_skip_on_bit_zero = 4'h4,
        op_table_read_paged = 4'h5,
        op_table_read_last_page = 4'h6,
        op_inc_table_read_paged = 4'h7,
        op_inc_table_read_last_page = 4'h8,
        op_xor_into_acc = 4'h9,
        op_xor_into_memory = 4'ha
    } op_e;
    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_fetch = 2'b01,
        st_skip = 2'b10
    } state_e;
endpackage

/* File: testbench/prog_mem_model.sv */
// program memory model facing the extended-group execution unit
// assumes the unit samples the word while prog_rd is high
`timescale 1ns/1ps
module prog_mem_model (
    // clock
    input wire logic clk_sys,
    // read port
    input wire logic [10:0] prog_addr,
    input wire logic prog_rd,
    output logic [15:0] prog_data
);
    logic [7:0] noise = 8'h96;
    // outside a read the word churns, so a mistimed sample cannot match
    always @(posedge clk_sys) begin
        noise <= noise + 8'h3b;
    end
    assign prog_data = prog_rd ? {5'h15, prog_addr[10:8], prog_addr[7:0] ^ 8'h5a} : {noise, ~noise};
endmodule // prog_mem_model

/* File: testbench/tb.sv */
// self-checking bench for the extended-group execution unit
// assumes the program memory model answers in the prog_rd cycle
`timescale 1ns/1ps
module tb;
    import ext_exec_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic start = 1'b0;
    op_e op = op_none;
    logic [7:0] operand = 8'h00;
    logic [2:0] bit_sel = 3'h0;
    logic ptr_load = 1'b0;
    logic [7:0] ptr_low_in = 8'h00;
    logic [7:0] ptr_high_in = 8'h00;
    logic [10:0] prog_addr;
    logic [15:0] prog_data;
    logic [7:0] accumulator, mem_wdata, table_pointer_low, table_pointer_high, table_high_latch;
    logic prog_rd, zero_flag, mem_we, skip_next, busy, done, skip_seen, we_seen;
    logic [7:0] exp_acc = 8'h00;
    int err_count = 0;
    int cmp_count = 0;
    int cyc;
    always #10 clk_sys = ~clk_sys;
    ext_exec dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .start(start), .op(op), .operand(operand),
        .bit_sel(bit_sel), .ptr_load(ptr_load), .ptr_low_in(ptr_low_in),
        .ptr_high_in(ptr_high_in), .prog_addr(prog_addr), .prog_rd(prog_rd),
        .prog_data(prog_data), .accumulator(accumulator), .zero_flag(zero_flag),
        .mem_we(mem_we), .mem_wdata(mem_wdata), .table_pointer_low(table_pointer_low),
        .table_pointer_high(table_pointer_high), .table_high_latch(table_high_latch),
        .skip_next(skip_next), .busy(busy), .done(done));
    prog_mem_model mem_u (.clk_sys(clk_sys), .prog_addr(prog_addr), .prog_rd(prog_rd),
        .prog_data(prog_data));

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // issues one instruction, counts cycles up to done
    task automatic run(input op_e o, input logic [7:0] v, input logic [2:0] b);
        @(posedge clk_sys);
        start <= 1'b1;
        op <= o;
        operand <= v;
        bit_sel <= b;
        @(posedge clk_sys);
        start <= 1'b0;
        skip_seen = 1'b0;
        we_seen = 1'b0;
        for (cyc = 1; cyc <= 8; cyc++) begin
            #1;
            if (skip_next === 1'b1) skip_seen = 1'b1;
            if (mem_we === 1'b1) we_seen = 1'b1;
            if (done === 1'b1) break;
            @(posedge clk_sys);
        end
        if (cyc > 8) begin
            chk("done", 16'h1, 16'h0);
            close_out();
        end
    endtask

    task automatic xor_and_swap();
        run(op_xor_into_acc, 8'h00, 3'h0);
        chk("zero_flag", 16'h1, zero_flag);
        run(op_swap_nibbles_to_acc, 8'h3c, 3'h0);
        chk("accumulator", 16'hc3, accumulator);
        chk("zero_flag", 16'h1, zero_flag);
        chk("mem_we", 16'h0, we_seen);
        run(op_xor_into_acc, 8'h98, 3'h0);
        chk("accumulator", 16'h5b, accumulator);
        chk("zero_flag", 16'h0, zero_flag);
        run(op_xor_into_memory, 8'h5b, 3'h0);
        chk("mem_wdata", 16'h00, mem_wdata);
        chk("mem_we", 16'h1, we_seen);
        chk("zero_flag", 16'h1, zero_flag);
        chk("accumulator", 16'h5b, accumulator);
        exp_acc = 8'h5b;
    endtask

    // even entries take the skip, odd ones fall through
    task automatic skip_cases();
        op_e ops[6] = '{op_skip_on_zero, op_skip_on_zero, op_copy_and_skip_on_zero,
            op_copy_and_skip_on_zero, op_skip_on_bit_zero, op_skip_on_bit_zero};
        logic [7:0] vals[6] = '{8'h00, 8'h80, 8'h00, 8'h01, 8'hfb, 8'hfb};
        logic [2:0] bits[6] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h2, 3'h3};
        for (int i = 0; i < 6; i++) begin
            run(ops[i], vals[i], bits[i]);
            if (ops[i] == op_copy_and_skip_on_zero) exp_acc = vals[i];
            chk("cycles", (i % 2 == 0) ? 16'h3 : 16'h1, cyc[15:0]);
            chk("skip_next", (i % 2 == 0) ? 16'h1 : 16'h0, skip_seen);
            chk("accumulator", exp_acc, accumulator);
            chk("zero_flag", 16'h1, zero_flag);
            chk("busy", 16'h0, busy);
        end
    endtask

    // pointer low ff exposes a wrong carry into the high byte
    task automatic table_cases();
        op_e ops[4] = '{op_table_read_paged, op_table_read_last_page, op_inc_table_read_paged,
            op_inc_table_read_last_page};
        logic [10:0] addrs[4] = '{11'h3ff, 11'h7ff, 11'h300, 11'h701};
        logic [7:0] lows[4] = '{8'hff, 8'hff, 8'h00, 8'h01};
        logic [15:0] w;
        @(posedge clk_sys);
        ptr_load <= 1'b1;
        ptr_low_in <= 8'hff;
        ptr_high_in <= 8'h03;
        @(posedge clk_sys);
        ptr_load <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            w = {5'h15, addrs[i][10:8], addrs[i][7:0] ^ 8'h5a};
            run(ops[i], 8'h00, 3'h0);
            chk("cycles", 16'h2, cyc[15:0]);
            chk("mem_wdata", w[7:0], mem_wdata);
            chk("table_high_latch", w[15:8], table_high_latch);
            chk("table_pointer_low", lows[i], table_pointer_low);
            chk("table_pointer_high", 16'h03, table_pointer_high);
            chk("accumulator", exp_acc, accumulator);
            chk("busy", 16'h0, busy);
        end
    endtask

    initial begin
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        xor_and_swap();
        skip_cases();
        table_cases();
        close_out();
    end
endmodule // tb
